/* File: rtl/keypad_ghost_filter.sv */
// key-detection sequencer with ghost filter and run-bit soft reset
`timescale 1ns/1ps
`default_nettype none
`include "keypad_defs.svh"
module keypad_ghost_filter #(
  parameter int DEBOUNCE_CYCLES = `KP_DEBOUNCE_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  // static current sense, bit {row_line, column_line} high while pressed
  input  wire keypad_pkg::key_map_t key_sense,
  // register write, already decoded from the serial frame
  input  wire logic                 wr_en,
  input  wire logic [7:0]           wr_cmd,
  input  wire logic [7:0]           wr_data,
  // register read
  input  wire logic                 rd_en,
  input  wire logic [7:0]           rd_cmd,
  output logic      [7:0]           rd_data,
  output logic                      rd_valid,
  // key events toward the event queue
  output logic                      evt_valid,
  output logic                      evt_release,
  output keypad_pkg::key_idx_t      evt_key,
  input  wire logic                 evt_ready,
  // sequencer status
  output logic                      detect_run_bit,
  output logic                      debounce_active
);
  import keypad_pkg::*;

  localparam logic [31:0] DEB_LAST = 32'(DEBOUNCE_CYCLES - 1);

  seq_state_t  state_ff;
  seq_state_t  nxt_state;
  logic [7:0]  cfg_ff;
  logic [7:0]  rd_data_ff;
  logic        rd_valid_ff;
  key_map_t    rep_ff;
  key_map_t    snap_ff;
  key_map_t    stable_ff;
  key_idx_t    idx_ff;
  logic [31:0] cnt_ff;
  logic        evt_valid_ff;
  logic        evt_release_ff;
  key_idx_t    evt_key_ff;

  ghost_if gif ();

  ghost_check u_ghost (
    .g (gif.chk)
  );

  // decode of register traffic
  wire cfg_hit   = wr_en && (wr_cmd == `KP_CFG_ADDR);
  wire cfg_rdhit = rd_en && (rd_cmd == `KP_CFG_ADDR);
  wire run       = cfg_ff[`KP_RUN_BIT];

  // candidate key for the ghost check is the scan pointer
  assign gif.pressed = rep_ff;
  assign gif.row     = idx_ff[5:3];
  assign gif.col     = idx_ff[2:0];

  wire cur_stable  = stable_ff[idx_ff];
  wire cur_diff    = cur_stable ^ rep_ff[idx_ff];
  // a press that would complete a rectangle stays pending, releases
  // always go out so the reported map can only shrink toward safety
  wire cur_blocked = cur_stable && gif.ghost;
  wire cur_emit    = cur_diff && !cur_blocked;
  wire last_key    = (idx_ff == `KP_LAST_KEY);
  // debounce only starts when something differs; an idle matrix with no
  // keys and nothing reported leaves the counter frozen
  wire activity    = (key_sense != rep_ff);
  wire sense_moved = (key_sense != snap_ff);
  wire deb_done    = (cnt_ff >= DEB_LAST);
  wire evt_taken   = evt_valid_ff && evt_ready;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RESET: begin
        // leaving here only on a set run bit restarts the whole sequence
        if (run) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (activity) begin
          nxt_state = ST_DEBOUNCE;
        end
      end
      ST_DEBOUNCE: begin
        if (!sense_moved && deb_done) begin
          nxt_state = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (cur_emit) begin
          nxt_state = ST_EMIT;
        end else if (last_key) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_EMIT: begin
        // sink full stalls the scan; only a cleared run bit drops the pending event
        if (evt_taken) begin
          nxt_state = last_key ? ST_IDLE : ST_SCAN;
        end
      end
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
    // a cleared run bit overrides every state
    if (!run) begin
      nxt_state = ST_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // configuration register, run bit set from reset for normal detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= `KP_CFG_RESET;
    end else if (cfg_hit) begin
      cfg_ff <= wr_data;
    end
  end

  // read port answers one cycle after the request, unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff  <= cfg_rdhit ? cfg_ff : 8'h00;
      rd_valid_ff <= rd_en;
    end
  end

  // debounce snapshot and counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap_ff <= '0;
      cnt_ff  <= 32'h0000_0000;
    end else if (state_ff == ST_IDLE) begin
      snap_ff <= key_sense;
      cnt_ff  <= 32'h0000_0000;
    end else if (state_ff == ST_DEBOUNCE) begin
      if (sense_moved) begin
        snap_ff <= key_sense;
        cnt_ff  <= 32'h0000_0000;
      end else if (!deb_done) begin
        cnt_ff  <= cnt_ff + 32'h0000_0001;
      end
    end else begin
      cnt_ff  <= 32'h0000_0000;
    end
  end

  // debounced map is frozen for the whole scan
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stable_ff <= '0;
    end else if (state_ff == ST_RESET) begin
      stable_ff <= '0;
    end else if ((state_ff == ST_DEBOUNCE) && (nxt_state == ST_SCAN)) begin
      stable_ff <= snap_ff;
    end
  end

  // scan pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_ff <= 6'h00;
    end else if (state_ff == ST_DEBOUNCE) begin
      idx_ff <= 6'h00;
    end else if ((state_ff == ST_SCAN) && !cur_emit && !last_key) begin
      idx_ff <= idx_ff + 6'h01;
    end else if ((state_ff == ST_EMIT) && evt_taken && !last_key) begin
      idx_ff <= idx_ff + 6'h01;
    end else if (state_ff == ST_RESET) begin
      idx_ff <= 6'h00;
    end
  end

  // reported map follows only what actually left as an event; held keys
  // are forgotten on a soft reset and report again as fresh presses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rep_ff <= '0;
    end else if (state_ff == ST_RESET) begin
      rep_ff <= '0;
    end else if ((state_ff == ST_EMIT) && evt_taken) begin
      rep_ff[idx_ff] <= stable_ff[idx_ff];
    end
  end

  // event register, held until the sink takes it or the run bit clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_valid_ff   <= 1'b0;
      evt_release_ff <= 1'b0;
      evt_key_ff     <= 6'h00;
    end else if (!run) begin
      evt_valid_ff   <= 1'b0;
    end else if ((state_ff == ST_SCAN) && cur_emit) begin
      evt_valid_ff   <= 1'b1;
      evt_release_ff <= !cur_stable;
      evt_key_ff     <= idx_ff;
    end else if (evt_taken) begin
      evt_valid_ff   <= 1'b0;
    end
  end

  assign rd_data         = rd_data_ff;
  assign rd_valid        = rd_valid_ff;
  assign evt_valid       = evt_valid_ff;
  assign evt_release     = evt_release_ff;
  assign evt_key         = evt_key_ff;
  assign detect_run_bit  = run;
  assign debounce_active = (state_ff == ST_DEBOUNCE);

endmodule
`default_nettype wire

/* File: include/keypad_defs.svh */
// constants for the keypad ghost filter and soft-reset sequencer
// Behaviour
// - A press forming the third corner of a key rectangle is withheld.
// - No phantom key event ever leaves, so some three-key chords are lost.
// - Any key count is taken while no ghost arises and the sink has room.
// - Keys are sensed statically; debounce starts only when the sensed map differs from the reported one.
// - In normal detection the run bit, bit 7 of register 0x01, is 1.
// - A run bit going from 0 to 1 restarts the sequencer from its start.
// - A write stores its data byte in the register its command selects.
`ifndef KEYPAD_DEFS_SVH
`define KEYPAD_DEFS_SVH

`define KP_CFG_ADDR       8'h01
`define KP_CFG_RESET      8'h80
`define KP_RUN_BIT        7
`define KP_NUM_KEYS       64
`define KP_CLK_MHZ        50
`define KP_DEBOUNCE_US    1000
`define KP_DEBOUNCE_CYC   (`KP_DEBOUNCE_US * `KP_CLK_MHZ)
`define KP_LAST_KEY       6'h3f

`endif

/* File: include/keypad_pkg.sv */
// types for the keypad ghost filter and soft-reset sequencer
package keypad_pkg;

  typedef enum logic [4:0] {
    ST_RESET    = 5'b00001,
    ST_IDLE     = 5'b00010,
    ST_DEBOUNCE = 5'b00100,
    ST_SCAN     = 5'b01000,
    ST_EMIT     = 5'b10000
  } seq_state_t;

  typedef logic [5:0]  key_idx_t;
  typedef logic [63:0] key_map_t;

endpackage

/* File: include/ghost_if.sv */
// carrier between the sequencer and its ghost checker
`timescale 1ns/1ps
`default_nettype none
interface ghost_if;
  logic [63:0] pressed;
  logic [2:0]  row;
  logic [2:0]  col;
  logic        ghost;

  modport req (output pressed, output row, output col, input ghost);
  modport chk (input pressed, input row, input col, output ghost);
endinterface
`default_nettype wire

/* File: rtl/ghost_check.sv */
// ghost-corner detector for one candidate key against the reported map
`timescale 1ns/1ps
`default_nettype none
module ghost_check (
  ghost_if.chk g
);

  // candidate (row, col) plus any two of the three other corners of some
  // rectangle makes a ghost; the candidate is then the key to withhold
  always_comb begin
    logic hit;
    logic a;
    logic b;
    logic d;
    hit = 1'b0;
    a   = 1'b0;
    b   = 1'b0;
    d   = 1'b0;
    for (int r2 = 0; r2 < 8; r2++) begin
      for (int c2 = 0; c2 < 8; c2++) begin
        if ((r2[2:0] != g.row) && (c2[2:0] != g.col)) begin
          a = g.pressed[{g.row, c2[2:0]}];
          b = g.pressed[{r2[2:0], g.col}];
          d = g.pressed[{r2[2:0], c2[2:0]}];
          hit = hit | (a & b) | (a & d) | (b & d);
        end
      end
    end
    g.ghost = hit;
  end

endmodule
`default_nettype wire

/* File: tb/host_writer.sv */
// host model issuing configuration writes
`timescale 1ns/1ps
`default_nettype none
module host_writer (
  input  wire logic  clk,
  output logic       wr_en,
  output logic [7:0] wr_cmd,
  output logic [7:0] wr_data
);
  initial {wr_en, wr_cmd, wr_data} = '0;
  task automatic put(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk) #1;
    wr_en = 1'b1;
    wr_cmd = c;
    wr_data = d;
    @(posedge clk) #1;
    wr_en = 1'b0;
    wr_data = ~d; // released bus never shows the old byte
  endtask
endmodule
`default_nettype wire

/* File: tb/keypad_ghost_filter_assertions.sv */
// port-level checks for the keypad sequencer
`timescale 1ns/1ps
`default_nettype none
module keypad_ghost_filter_assertions (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       wr_en,
  input wire logic [7:0] wr_cmd,
  input wire logic [7:0] wr_data,
  input wire logic       rd_en,
  input wire logic       rd_valid,
  input wire logic       evt_valid,
  input wire keypad_pkg::key_idx_t evt_key,
  input wire logic       evt_ready,
  input wire logic       detect_run_bit,
  input wire logic       debounce_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence run_off;
    !detect_run_bit [*2]; // halt lands one edge after the run bit drops
  endsequence
  rd_echo_a: assert property (rd_valid == $past(rd_en))
    else $error("read valid");
  cfg_write_a: assert property (wr_en && wr_cmd == 8'h01 |=>
    detect_run_bit == $past(wr_data[7])) else $error("run bit");
  cfg_other_a: assert property (wr_en && wr_cmd != 8'h01 |=>
    $stable(detect_run_bit)) else $error("stray write");
  halt_quiet_a: assert property (run_off |-> !evt_valid)
    else $error("halted event");
  halt_nodeb_a: assert property (run_off |-> !debounce_active)
    else $error("halted debounce");
  // an offer launched on the edge that clears the run bit is legal
  evt_run_a: assert property ($rose(evt_valid) |-> $past(detect_run_bit))
    else $error("event off run");
  // a cleared run bit may drop an untaken offer, so only hold while running
  offer_hold_a: assert property (evt_valid && !evt_ready && detect_run_bit
    |=> evt_valid && $stable(evt_key)) else $error("offer lost");
  offer_gap_a: assert property (evt_valid && evt_ready |=> !evt_valid)
    else $error("no gap");
endmodule
bind keypad_ghost_filter keypad_ghost_filter_assertions
  keypad_ghost_filter_assertions_inst (.clk, .rst, .wr_en, .wr_cmd,
  .wr_data, .rd_en, .rd_valid, .evt_valid, .evt_key, .evt_ready,
  .detect_run_bit, .debounce_active);
`default_nettype wire

/* File: tb/tb_keypad_ghost_filter.sv */
// self-checking bench for the keypad sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_keypad_ghost_filter;
  import keypad_pkg::*;
  logic       clk, rst, rd_en, rd_valid, evt_valid, evt_release;
  logic       evt_ready, wr_en, detect_run_bit, debounce_active;
  logic [7:0] wr_cmd, wr_data, rd_cmd, rd_data, c;
  key_map_t   key_sense, m;
  key_idx_t   evt_key;
  logic [6:0] got[$];
  int         num_errors, tests_run, seed;
  keypad_ghost_filter #(.DEBOUNCE_CYCLES(4)) keypad_ghost_filter_inst (
    .clk, .rst, .key_sense, .wr_en, .wr_cmd, .wr_data, .rd_en, .rd_cmd,
    .rd_data, .rd_valid, .evt_valid, .evt_release, .evt_key, .evt_ready,
    .detect_run_bit, .debounce_active);
  host_writer host_writer_inst (.clk, .wr_en, .wr_cmd, .wr_data);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) #1 evt_ready = 1'($random(seed));
  always @(negedge clk) if (evt_valid === 1'b1 && evt_ready === 1'b1)
    got.push_back({evt_release, evt_key}); // mid-cycle, no edge race
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #1;
    rd_en = 1'b1;
    rd_cmd = a;
    @(posedge clk) #1;
    rd_en = 1'b0;
    chk(rd_valid === 1'b1 ? rd_data : 8'hxx, e);
  endtask
  task automatic run(input key_map_t s);
    @(posedge clk) #1;
    key_sense = s;
    got.delete();
    repeat (200) @(posedge clk); // spans debounce and one full scan
  endtask
  task automatic expect_evts(input key_map_t a, input key_map_t b);
    int n = 0;
    for (int k = 0; k < 64; k++)
      if (a[k] != b[k]) begin
        chk(n < got.size() ? {1'b0, got[n]} : 8'hff, {1'b0, a[k], k[5:0]});
        n++;
      end
    chk(8'(got.size()), 8'(n));
    $display("test done, %0d events", n);
  endtask
  task automatic end_sim;
    $display("checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    seed = 51;
    rst = 1'b1;
    {rd_en, rd_cmd, key_sense} = '0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    rdc(8'h01, 8'h80);
    c = 8'($random(seed)) | 8'h02;
    host_writer_inst.put(c, 8'($random(seed)));
    rdc(c, 8'h00);
    $display("test done, register access");
    repeat (3) begin
      m = {$random(seed), $random(seed)} & 64'h8040201008040201;
      run(m);
      expect_evts('0, m);
      run('0);
      expect_evts(m, '0);
      chk({7'h00, debounce_active}, 8'h00);
    end
    host_writer_inst.put(8'h01, 8'h00);
    chk({7'h00, detect_run_bit}, 8'h00);
    run(64'hff);
    chk(8'(got.size()), 8'h00);
    $display("test done, halted sequencer");
    c = 8'($random(seed)) | 8'h80;
    host_writer_inst.put(8'h01, c);
    run(64'hff);
    expect_evts('0, 64'hff);
    rdc(8'h01, c);
    run(64'h0303);
    expect_evts(64'hff, 64'h03);
    end_sim();
  end
endmodule
`default_nettype wire
